/* shared/pir_pkg.sv */
package pir_pkg;

    localparam int CLK_HZ = 100_000_000;
    localparam int OSC_HZ = 32_000;
    localparam logic [11:0] TICK_CYCLES = 12'(CLK_HZ / OSC_HZ);

    localparam logic [2:0] SETUP_TICKS = 3'h3;
    localparam logic [2:0] ABORT_TICKS = 3'h4;
    localparam logic [5:0] PKT_TICKS = 6'h20;
    localparam logic [9:0] PERIOD_TICKS = 10'h200;
    localparam logic [9:0] SHORT_TICKS = 10'h200;
    localparam int BLIND_UNIT_MS = 500;
    localparam int BLIND_UNIT_TICKS = BLIND_UNIT_MS * OSC_HZ / 1000;
    localparam int BIT_HOLD_NS = 2000;
    localparam logic [7:0] BIT_HOLD_CYCLES = 8'((BIT_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000);

    localparam logic [13:0] ADC_LOW = 14'h01FF;
    localparam logic [13:0] ADC_SHORT_HI = 14'h3E00;
    localparam logic [13:0] ADC_MAX_OUT = 14'h3E01;
    localparam logic [13:0] ADC_RESET = 14'h01FF;

    localparam logic [5:0] PKT_LAST = 6'h27;
    localparam int ADC_LSB = 25;
    localparam int MODE_LSB = 7;
    localparam int SRC_LSB = 5;
    localparam int BLIND_LSB = 13;
    localparam logic [24:0] CFG_RESET = 25'h0000010;

    localparam logic [1:0] MODE_FORCED = 2'h0;
    localparam logic [1:0] MODE_PERIODIC = 2'h1;
    localparam logic [1:0] MODE_WAKE = 2'h2;
    localparam logic [1:0] SRC_BAND_PASS = 2'h0;

    localparam logic [3:0] REG_CONFIG = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_ADC = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_IRQ = 2'b01,
        ST_WAIT = 2'b10,
        ST_DRIVE = 2'b11
    } pir_state_type;

    // Maps a byte address to a register index, 3 when unmapped.
    function automatic logic [1:0] pir_sel(input logic [3:0] addr);
        if (addr == REG_CONFIG) begin
            return 2'h0;
        end else if (addr == REG_STATUS) begin
            return 2'h1;
        end else if (addr == REG_ADC) begin
            return 2'h2;
        end else begin
            return 2'h3;
        end
    endfunction : pir_sel

    // Blind interval in oscillator ticks. [R22]
    function automatic logic [17:0] pir_blind_ticks(input logic [3:0] b);
        return 18'((int'(b) + 1) * BLIND_UNIT_TICKS);
    endfunction : pir_blind_ticks

endpackage : pir_pkg

/* core/pir_sync.sv */
`timescale 1ns/1ps
module pir_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic d,
    output logic q
);
    logic meta_ff;
    logic nxt_meta;
    logic nxt_q;

    always_comb begin
        nxt_meta = d;
        nxt_q = meta_ff;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_ff <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_ff <= nxt_meta;
            q <= nxt_q;
        end
    end
endmodule : pir_sync

/* core/pir_tick.sv */
`timescale 1ns/1ps
module pir_tick (
    input wire logic aclk,
    input wire logic aresetn,
    output logic tick
);
    import pir_pkg::*;

    logic [11:0] cnt_ff;
    logic [11:0] nxt_cnt;
    logic nxt_tick;

    // Stands in for the internal oscillator: one pulse per oscillator period.
    always_comb begin
        nxt_tick = (cnt_ff == TICK_CYCLES - 12'h001);
        nxt_cnt = nxt_tick ? 12'h000 : cnt_ff + 12'h001;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff <= 12'h000;
            tick <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            tick <= nxt_tick;
        end
    end
endmodule : pir_tick

/* core/pir_readout.sv */
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// Contract
// R1: Host starts a forced read-out by holding the line high three oscillator ticks.
// R2: Each host rising edge after setup makes the device present the next bit.
// R3: Bits leave most significant first down to bit 0 until the packet ends.
// R4: After bit 0 the host drives the line low, then releases it.
// R5: Host keeps each bit period within one tick, never low beyond 22 us.
// R6: Host reads a whole packet within 32 oscillator ticks.
// R7: Host starts with bit periods just under 22 us, then shortens them. pir_host uses one fixed period of 38 lclk (about 3 us).
// R8: Host aborts by holding the line low four ticks, then releasing it.
// R9: Periodic mode drives the line high every 512 ticks.
// R10: In periodic mode the host finishes each packet before the next high.
// R11: Wake mode drives the line high on motion and keeps it latched.
// R12: Host clears a motion alarm by pulling the line low one tick.
// R13: Clearing a motion alarm blocks motion detection for the blind interval.
// R14: After an interrupt, the first rising edge yields the MSB without setup.
// R15: No interrupt is raised while the host is using the line.
// R16: Out-of-range conversions short the converter input for 512 ticks.
// R17: The packet's converter value lies between 511 and 2^14 minus 511.
// R18: Host sample interval is at least 2 ms, at most 12.5 ms when periodic. The testbench reads closer together than 2 ms.
// R19: Packet is 40 bits: zero, 14-bit converter value, 25-bit configuration.
// R20: Converter value is two's complement for band-pass source, else unsigned.
// R21: Mode 0 forced, 1 periodic, 2 wake-up on motion, 3 reserved.
// R22: Blind interval is 0.5 s plus the blind setting times 0.5 s.
// R23: Host releases after each strobe and samples the bit before going low.
// R24: Device drives the line only for a bit or an interrupt high.
module pir_readout (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [13:0] adc_sample,
    input wire logic adc_valid,
    input wire logic motion_event,
    input wire logic dl_i,
    output logic dl_o,
    output logic dl_oe_n,
    output logic adc_short
);
    import pir_pkg::*;

    logic tick;
    logic line_s;
    pir_state_type state_ff, nxt_state;
    logic line_q_ff, nxt_line_q;
    logic [5:0] idx_ff, nxt_idx;
    logic [2:0] lvl_cnt_ff, nxt_lvl_cnt;
    logic [5:0] pkt_cnt_ff, nxt_pkt_cnt;
    logic [7:0] hold_ff, nxt_hold;
    logic [39:0] pkt_ff, nxt_pkt;
    logic [9:0] period_ff, nxt_period;
    logic [17:0] blind_ff, nxt_blind;
    logic [9:0] short_ff, nxt_short;
    logic [13:0] adc_ff, nxt_adc;
    logic motion_ff, nxt_motion;
    logic nxt_dl_o, nxt_dl_oe_n, nxt_adc_short;
    logic [24:0] cfg_ff, nxt_cfg;
    logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0] mode, src;
    logic rise, fall, period_hit, irq_ok, cur_bit, wr_go, rd_go, out_range;
    logic [17:0] blind_load;
    logic [39:0] pkt_build;
    logic [13:0] adc_word;
    logic [1:0] wsel, rsel;

    pir_tick u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick)
    );

    pir_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(dl_i),
        .q(line_s)
    );

    assign mode = cfg_ff[MODE_LSB +: 2]; // [R21]
    assign src = cfg_ff[SRC_LSB +: 2];
    assign rise = line_s & ~line_q_ff;
    assign fall = ~line_s & line_q_ff; // [R12]
    assign cur_bit = pkt_ff[idx_ff];
    assign blind_load = pir_blind_ticks(cfg_ff[BLIND_LSB +: 4]); // [R22]
    assign period_hit = tick && (period_ff == PERIOD_TICKS - 10'h001);
    assign irq_ok = (state_ff == ST_IDLE) && !line_s; // [R15]
    assign out_range = adc_valid && ((adc_sample > ADC_SHORT_HI) || (adc_sample < ADC_LOW));
    assign adc_word = (src == SRC_BAND_PASS) ? {~adc_ff[13], adc_ff[12:0]} : adc_ff; // [R20]
    assign pkt_build = {1'b0, adc_word, cfg_ff}; // [R19]

    always_comb begin
        nxt_state = state_ff;
        nxt_line_q = line_s;
        nxt_idx = idx_ff;
        nxt_lvl_cnt = lvl_cnt_ff;
        nxt_pkt_cnt = pkt_cnt_ff;
        nxt_hold = hold_ff;
        nxt_pkt = pkt_ff;
        nxt_period = period_hit ? 10'h000 : period_ff + {9'h000, tick};
        nxt_blind = (blind_ff != 18'h00000 && tick) ? blind_ff - 18'h00001 : blind_ff;
        nxt_short = (short_ff != 10'h000 && tick) ? short_ff - 10'h001 : short_ff;
        nxt_adc = adc_ff;
        nxt_motion = motion_ff;
        if (mode != MODE_PERIODIC) begin
            nxt_period = 10'h000;
        end
        if (adc_valid) begin
            if (adc_sample < ADC_LOW) begin
                nxt_adc = ADC_LOW; // [R17]
            end else if (adc_sample > ADC_MAX_OUT) begin
                nxt_adc = ADC_MAX_OUT; // [R17]
            end else begin
                nxt_adc = adc_sample;
            end
        end
        if (out_range) begin
            nxt_short = SHORT_TICKS; // [R16]
        end
        case (state_ff)
            ST_IDLE: begin
                nxt_lvl_cnt = line_s ? lvl_cnt_ff + {2'h0, tick} : 3'h0;
                if (line_s && lvl_cnt_ff >= SETUP_TICKS) begin
                    nxt_state = ST_WAIT;
                    nxt_pkt = pkt_build;
                end else if (mode == MODE_PERIODIC && period_hit && irq_ok) begin
                    nxt_state = ST_IRQ; // [R9]
                    nxt_pkt = pkt_build;
                end else if (mode == MODE_WAKE && motion_ff && irq_ok) begin
                    nxt_state = ST_IRQ; // [R11]
                    nxt_pkt = pkt_build;
                    nxt_motion = 1'b0;
                end
                nxt_idx = PKT_LAST;
                nxt_pkt_cnt = 6'h00;
                if (nxt_state != ST_IDLE) begin
                    nxt_lvl_cnt = 3'h0;
                end
            end
            ST_IRQ: begin
                // Clear on a fall, as the synchroniser still shows low just after entry.
                if (fall) begin
                    nxt_state = ST_WAIT; // [R14]
                    nxt_idx = PKT_LAST;
                    if (mode == MODE_WAKE) begin
                        nxt_blind = blind_load; // [R13]
                        nxt_motion = 1'b0; // [R13]
                    end
                end
            end
            ST_WAIT: begin
                nxt_lvl_cnt = line_s ? 3'h0 : lvl_cnt_ff + {2'h0, tick};
                nxt_pkt_cnt = pkt_cnt_ff + {5'h00, tick};
                if (rise) begin
                    nxt_state = ST_DRIVE; // [R2]
                    nxt_hold = BIT_HOLD_CYCLES;
                end else if (lvl_cnt_ff >= ABORT_TICKS || pkt_cnt_ff >= PKT_TICKS) begin
                    nxt_state = ST_IDLE;
                end
                if (nxt_state != ST_WAIT) begin
                    nxt_lvl_cnt = 3'h0;
                end
            end
            ST_DRIVE: begin
                nxt_pkt_cnt = pkt_cnt_ff + {5'h00, tick};
                nxt_hold = hold_ff - 8'h01;
                if (hold_ff == 8'h00) begin
                    if (idx_ff == 6'h00) begin
                        nxt_state = ST_IDLE;
                    end else begin
                        nxt_state = ST_WAIT;
                        nxt_idx = idx_ff - 6'h01; // [R3]
                    end
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        if (motion_event && mode == MODE_WAKE && nxt_blind == 18'h00000) begin
            nxt_motion = 1'b1; // [R13]
        end
        nxt_dl_oe_n = !(nxt_state == ST_IRQ || nxt_state == ST_DRIVE); // [R24]
        nxt_dl_o = (nxt_state == ST_IRQ) || (nxt_state == ST_DRIVE && nxt_pkt[nxt_idx]);
        nxt_adc_short = (nxt_short != 10'h000);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= ST_IDLE;
            line_q_ff <= 1'b0;
            idx_ff <= PKT_LAST;
            lvl_cnt_ff <= 3'h0;
            pkt_cnt_ff <= 6'h00;
            hold_ff <= 8'h00;
            pkt_ff <= 40'h0000000000;
            period_ff <= 10'h000;
            blind_ff <= 18'h00000;
            short_ff <= 10'h000;
            adc_ff <= ADC_RESET;
            motion_ff <= 1'b0;
            dl_o <= 1'b0;
            dl_oe_n <= 1'b1;
            adc_short <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            line_q_ff <= nxt_line_q;
            idx_ff <= nxt_idx;
            lvl_cnt_ff <= nxt_lvl_cnt;
            pkt_cnt_ff <= nxt_pkt_cnt;
            hold_ff <= nxt_hold;
            pkt_ff <= nxt_pkt;
            period_ff <= nxt_period;
            blind_ff <= nxt_blind;
            short_ff <= nxt_short;
            adc_ff <= nxt_adc;
            motion_ff <= nxt_motion;
            dl_o <= nxt_dl_o;
            dl_oe_n <= nxt_dl_oe_n;
            adc_short <= nxt_adc_short;
        end
    end

    // Register slave: a write is taken once address and data are both offered and no write response is pending.
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
    assign rd_go = s_axi_arvalid && !rvalid_ff;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = rdata_ff;
    assign wsel = pir_sel(s_axi_awaddr);
    assign rsel = pir_sel(s_axi_araddr);

    always_comb begin
        nxt_cfg = cfg_ff;
        nxt_bvalid = bvalid_ff && !s_axi_bready;
        nxt_bresp = bresp_ff;
        nxt_rvalid = rvalid_ff && !s_axi_rready;
        nxt_rresp = rresp_ff;
        nxt_rdata = rdata_ff;
        if (wr_go) begin
            nxt_bvalid = 1'b1;
            nxt_bresp = RESP_OKAY;
            if (wsel == 2'h0) begin
                for (int i = 0; i < 25; i++) begin
                    if (s_axi_wstrb[i / 8]) begin
                        nxt_cfg[i] = s_axi_wdata[i];
                    end
                end
            end else if (wsel == 2'h3) begin
                nxt_bresp = RESP_SLVERR;
            end
        end
        if (rd_go) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = RESP_OKAY;
            if (rsel == 2'h0) begin
                nxt_rdata = {7'h00, cfg_ff};
            end else if (rsel == 2'h1) begin
                nxt_rdata = {21'h000000, adc_short, blind_ff != 18'h00000, motion_ff,
                             state_ff, idx_ff};
            end else if (rsel == 2'h2) begin
                nxt_rdata = {18'h00000, adc_ff};
            end else begin
                nxt_rdata = 32'h00000000;
                nxt_rresp = RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_ff <= CFG_RESET;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            rvalid_ff <= 1'b0;
            rresp_ff <= RESP_OKAY;
            rdata_ff <= 32'h00000000;
        end else begin
            cfg_ff <= nxt_cfg;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rresp_ff <= nxt_rresp;
            rdata_ff <= nxt_rdata;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_strobe;
        state_ff == ST_WAIT && rise;
    endsequence

    sequence s_clear;
        state_ff == ST_IRQ && fall;
    endsequence

    property p_bit_out;
        s_strobe |=> !dl_oe_n && dl_o == $past(cur_bit) && state_ff == ST_DRIVE;
    endproperty
    a_bit_out: assert property (p_bit_out) else $error("Bit not presented on strobe."); // [R2]

    property p_shift;
        state_ff == ST_DRIVE && hold_ff == 8'h00 && idx_ff != 6'h00
            |=> state_ff == ST_WAIT && idx_ff == $past(idx_ff) - 6'h01;
    endproperty
    a_shift: assert property (p_shift) else $error("Bit index did not step down."); // [R3]

    property p_period;
        mode == MODE_PERIODIC && period_hit && irq_ok
            |=> state_ff == ST_IRQ && dl_o && !dl_oe_n;
    endproperty
    a_period: assert property (p_period) else $error("Periodic high missing."); // [R9]

    property p_latch;
        state_ff == ST_IRQ && line_s ##1 line_s |-> state_ff == ST_IRQ && dl_o;
    endproperty
    a_latch: assert property (p_latch) else $error("Interrupt high dropped by itself."); // [R11]

    property p_blind;
        s_clear and mode == MODE_WAKE |=> blind_ff == $past(blind_load) && !motion_ff;
    endproperty
    a_blind: assert property (p_blind) else $error("Blind interval not loaded."); // [R13]

    property p_msb_first;
        s_clear |=> state_ff == ST_WAIT && idx_ff == PKT_LAST ##1 state_ff != ST_IRQ;
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("Read after interrupt not at MSB."); // [R14]

    property p_no_irq;
        state_ff == ST_WAIT || state_ff == ST_DRIVE |=> state_ff != ST_IRQ;
    endproperty
    a_no_irq: assert property (p_no_irq) else $error("Interrupt during access."); // [R15]

    property p_short;
        out_range |=> short_ff == SHORT_TICKS ##1 adc_short;
    endproperty
    a_short: assert property (p_short) else $error("Converter short not started."); // [R16]

    property p_range;
        adc_ff >= ADC_LOW && adc_ff <= ADC_MAX_OUT;
    endproperty
    a_range: assert property (p_range) else $error("Converter value out of range."); // [R17]

    property p_packet;
        state_ff == ST_IDLE && nxt_state != ST_IDLE
            |=> !pkt_ff[39] && pkt_ff[24:0] == $past(cfg_ff)
                && pkt_ff[38] == ($past(adc_ff[13]) ^ ($past(src) == SRC_BAND_PASS));
    endproperty
    a_packet: assert property (p_packet) else $error("Packet layout wrong."); // [R19] [R20]

    property p_forced;
        mode == MODE_FORCED && state_ff == ST_IDLE |=> state_ff != ST_IRQ;
    endproperty
    a_forced: assert property (p_forced) else $error("Interrupt in forced mode."); // [R21]

    property p_release;
        !dl_oe_n |-> state_ff == ST_IRQ || state_ff == ST_DRIVE;
    endproperty
    a_release: assert property (p_release) else $error("Line driven outside bit or interrupt."); // [R24]

endmodule : pir_readout

/* tb/pir_host.sv */
`timescale 1ns/1ps
module pir_host (
    input wire logic lclk,
    input wire logic dl_o,
    input wire logic dl_oe_n,
    output logic dl_i
);
    localparam int SETUP_LCLK = 1563; // About four ticks, inside 110 to 150 us.
    logic drv = 1'b0;
    logic val = 1'b0;
    // Host low wins, a released line falls to the pull-down.
    assign dl_i = drv ? val : (!dl_oe_n ? dl_o : 1'b0);
    // Reads come closer than the 2 ms sample interval, to keep the run short.
    task setup();
        @(posedge lclk);
        drv <= 1'b1;
        val <= 1'b1;
        repeat (SETUP_LCLK) @(posedge lclk);
    endtask : setup
    task pull_low(input int n);
        @(posedge lclk);
        drv <= 1'b1;
        val <= 1'b0;
        repeat (n) @(posedge lclk);
        drv <= 1'b0;
        @(posedge lclk);
    endtask : pull_low
    task read_bits(input int n, output logic [39:0] v);
        v = '0;
        @(posedge lclk);
        repeat (n) begin
            drv <= 1'b1;
            val <= 1'b0;
            repeat (5) @(posedge lclk);
            val <= 1'b1;
            repeat (5) @(posedge lclk);
            drv <= 1'b0;
            repeat (10) @(posedge lclk);
            v = {v[38:0], dl_i};
            repeat (18) @(posedge lclk);
        end
    endtask : read_bits
endmodule : pir_host

/* tb/pir_single_wire_readout_tb.sv */
`timescale 1ns/1ps
module pir_single_wire_readout_tb;
    import pir_pkg::*;
    typedef struct {
        logic wr;
        logic [3:0] addr;
        logic [31:0] data;
        logic [1:0] resp;
    } pir_row_type;
    logic aclk = 1'b0, lclk = 1'b0, aresetn = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [13:0] adc_sample = 14'h0;
    logic adc_valid = 1'b0, motion_event = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, dl_i, dl_o, dl_oe_n, adc_short;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    logic [39:0] pkt;
    int bad_count = 0, num_checks = 0, cyc = 0, drv_cycles = 0, drv_base = 0;
    pir_row_type rows [8] = '{
        '{1'b0, 4'h0, 32'h0000_0010, 2'h0}, '{1'b0, 4'h8, 32'h0000_01FF, 2'h0},
        '{1'b1, 4'h0, 32'hFFFF_FFFF, 2'h0}, '{1'b0, 4'h0, 32'h01FF_FFFF, 2'h0},
        '{1'b1, 4'hC, 32'h0000_0070, 2'h2}, '{1'b0, 4'hC, 32'h0000_0000, 2'h2},
        '{1'b1, 4'h0, 32'h0000_0070, 2'h0}, '{1'b0, 4'h0, 32'h0000_0070, 2'h0}};

    pir_readout dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .adc_sample(adc_sample), .adc_valid(adc_valid),
        .motion_event(motion_event), .dl_i(dl_i), .dl_o(dl_o), .dl_oe_n(dl_oe_n),
        .adc_short(adc_short));
    pir_host host (.lclk(lclk), .dl_o(dl_o), .dl_oe_n(dl_oe_n), .dl_i(dl_i));

    initial begin
        forever #5 aclk = ~aclk;
    end
    initial begin
        #3;
        forever #40 lclk = ~lclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (aresetn && dl_oe_n === 1'b0) begin
            drv_cycles <= drv_cycles + 1;
        end
        if (cyc == 95000) begin
            bad_count++;
            give_verdict();
        end
    end

    task chk(input string name, input logic [39:0] seen, input logic [39:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge aclk); while (!(awready === 1'b1 && wready === 1'b1));
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask : axi_write
    task axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_read
    task pulse(input logic [13:0] s, input logic mot);
        adc_sample <= s;
        adc_valid <= !mot;
        motion_event <= mot;
        @(posedge aclk);
        adc_valid <= 1'b0;
        motion_event <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask : pulse
    task give_verdict();
        $display("Checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (3) @(posedge aclk);
        chk("oe_n_in_reset", dl_oe_n, 1'b1);
        chk("short_in_reset", adc_short, 1'b0);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                axi_write(rows[i].addr, rows[i].data, resp);
                chk("bresp", resp, rows[i].resp);
            end else begin
                axi_read(rows[i].addr, rd, resp);
                chk("rdata", rd, rows[i].data);
                chk("rresp", resp, rows[i].resp);
            end
        end
        pulse(14'h1234, 1'b0);
        chk("short_in_range", adc_short, 1'b0);
        axi_read(4'h8, rd, resp);
        chk("adc_reg", rd, 32'h0000_1234);
        drv_base = drv_cycles;
        host.setup();
        host.read_bits(40, pkt);
        host.pull_low(13);
        chk("forced_pkt", pkt, {1'b0, 14'h1234, 25'h70});
        chk("bit_drive_cycles", drv_cycles - drv_base, 40 * 201);
        host.setup();
        host.read_bits(3, pkt);
        chk("abort_head", pkt[2:0], 3'b001);
        host.pull_low(2000);
        drv_base = drv_cycles;
        host.read_bits(1, pkt);
        chk("after_abort", drv_cycles - drv_base, 0);
        @(posedge aclk);
        axi_write(4'h0, 32'h0000_0110, resp);
        pulse(14'h1234, 1'b1);
        repeat (50) @(posedge aclk);
        chk("irq_drive", {dl_oe_n, dl_o}, 2'b01);
        repeat (8000) @(posedge aclk);
        chk("irq_latched", dl_i, 1'b1);
        host.pull_low(400);
        host.read_bits(40, pkt);
        chk("wake_pkt", pkt, {1'b0, 14'h3234, 25'h110});
        @(posedge aclk);
        pulse(14'h1234, 1'b1);
        drv_base = drv_cycles;
        repeat (500) @(posedge aclk);
        chk("blind_motion", drv_cycles - drv_base, 0);
        pulse(14'h3F00, 1'b0);
        chk("short_high", adc_short, 1'b1);
        axi_read(4'h8, rd, resp);
        chk("adc_clamp_high", rd, 32'h0000_3E01);
        pulse(14'h0100, 1'b0);
        axi_read(4'h8, rd, resp);
        chk("adc_clamp_low", rd, 32'h0000_01FF);
        chk("short_held", adc_short, 1'b1);
        give_verdict();
    end
endmodule : pir_single_wire_readout_tb
